// ---- rtl/arf_relays.sv ----
// auxiliary relay flags top: calc relays, judgement, run request,
// trigger flag, ready mirror, behind an axi4-lite slave with irq
// assumes image and evaluation inputs are on aclk; ready_pin is not
//
// Functional notes
// [R01] A bank of 110 general calculation relays is kept for the program.
// [R02] While the clear relay is on, all calculation relays read as off.
// [R03] Final judgement is on when all used items are good, else off.
// [R04] A processing error forces the final judgement off.
// [R05] Without display override, the shown result follows the judgement.
// [R06] While the run request is held on, measurements start back to back.
// [R07] The trigger flag is refreshed from every image, start use or not.
// [R08] In binary mode the flag is on when white covers half the image.
// [R09] In average mode the flag is on when the level is inside the range.
// [R10] The ready mirror relay carries the external ready signal.
// [R11] The constant-off relay always reads as zero.
// [R12] The program both reads and drives the relays through registers.
`timescale 1ns/1ps
`default_nettype none
module arf_relays
  import arf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ready_pin,
  input wire arf_pkg::arf_image_stat_t image_stat,
  input wire arf_pkg::arf_eval_t eval_in,
  output logic meas_start,
  output logic final_judgement_relay,
  output logic trigger_condition_flag,
  output logic processing_error_flag,
  output logic ok_display,
  output logic irq
);
  import arf_pkg::*;

  arf_ctrl_t ctrl_r;
  logic [2:0] irq_stat_r, irq_mask_r, irq_event, irq_clear;
  logic [15:0] item_use_r, trig_lvl_r;
  logic ready_mirror_relay, busy_r, items_good, trig_nxt;
  logic aw_got_r, w_got_r, ar_got_r, rd_step_r;
  logic [7:0] awaddr_r, araddr_r;
  logic [31:0] wdata_r, calc_rdata, rd_mux;
  logic [3:0] wstrb_r;
  logic aw_fire, w_fire, b_fire, ar_fire, r_fire;
  logic do_write, wr_ok, calc_wr, rd_ok;

  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign b_fire = s_axi_bvalid && s_axi_bready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign r_fire = s_axi_rvalid && s_axi_rready;
  assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
  assign calc_wr = do_write && awaddr_r >= ADDR_CALC_FIRST &&
                   awaddr_r <= ADDR_CALC_LAST;

  // ready arrives from a pin, so it is resynchronised first
  arf_sync2 u_ready_sync (.aclk(aclk), .aresetn(aresetn), .din(ready_pin),
    .dout(ready_mirror_relay)); // R10

  arf_calc_bank u_calc_bank (.aclk(aclk), .aresetn(aresetn),
    .clear(ctrl_r.calc_clear), // R02
    .wr_en(calc_wr), // R12
    .wr_idx(awaddr_r[3:2]), .wdata(wdata_r), .wstrb(wstrb_r),
    .rd_idx(araddr_r[3:2]), .rdata(calc_rdata));

  // write address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= WORD_RST;
      wstrb_r <= 4'h0;
    end
    else
    begin
      s_axi_awready <= b_fire || (!aw_got_r && !aw_fire);
      s_axi_wready <= b_fire || (!w_got_r && !w_fire);
      if (aw_fire)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      else if (b_fire)
        aw_got_r <= 1'b0;
      if (w_fire)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (b_fire)
        w_got_r <= 1'b0;
    end
  end

  always_comb
  begin
    if (awaddr_r == ADDR_CTRL || awaddr_r == ADDR_STAT)
      wr_ok = 1'b1;
    else if (awaddr_r == ADDR_IRQ_STAT || awaddr_r == ADDR_IRQ_MASK)
      wr_ok = 1'b1;
    else if (awaddr_r == ADDR_ITEM_USE || awaddr_r == ADDR_TRIG_LVL)
      wr_ok = 1'b1;
    else if (awaddr_r >= ADDR_CALC_FIRST && awaddr_r <= ADDR_CALC_LAST)
      wr_ok = 1'b1;
    else
      wr_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (b_fire)
      s_axi_bvalid <= 1'b0;
  end

  // control registers written by the condition program
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= CTRL_RST;
      irq_mask_r <= IRQ_RST;
      item_use_r <= ITEM_USE_RST;
      trig_lvl_r <= TRIG_LVL_RST;
    end
    else if (do_write && wstrb_r[0])
    begin
      if (awaddr_r == ADDR_CTRL)
        ctrl_r <= wdata_r[4:0]; // R12
      else if (awaddr_r == ADDR_IRQ_MASK)
        irq_mask_r <= wdata_r[2:0];
      else if (awaddr_r == ADDR_ITEM_USE)
        item_use_r[7:0] <= wdata_r[7:0];
      else if (awaddr_r == ADDR_TRIG_LVL)
        trig_lvl_r[7:0] <= wdata_r[7:0];
    end
    if (aresetn && do_write && wstrb_r[1])
    begin
      if (awaddr_r == ADDR_ITEM_USE)
        item_use_r[15:8] <= wdata_r[15:8];
      else if (awaddr_r == ADDR_TRIG_LVL)
        trig_lvl_r[15:8] <= wdata_r[15:8];
    end
  end

  // read: one cycle for the bank's registered word, one for the mux
  always_comb
  begin
    rd_mux = WORD_RST;
    rd_ok = 1'b1;
    if (araddr_r == ADDR_CTRL)
      rd_mux = {27'h0, ctrl_r};
    else if (araddr_r == ADDR_STAT)
    begin
      rd_mux = {25'h0, busy_r, ok_display, 1'b0, processing_error_flag,
                ready_mirror_relay, trigger_condition_flag,
                final_judgement_relay}; // R11
    end
    else if (araddr_r == ADDR_IRQ_STAT)
      rd_mux = {29'h0, irq_stat_r};
    else if (araddr_r == ADDR_IRQ_MASK)
      rd_mux = {29'h0, irq_mask_r};
    else if (araddr_r >= ADDR_CALC_FIRST && araddr_r <= ADDR_CALC_LAST)
      rd_mux = calc_rdata; // R12
    else if (araddr_r == ADDR_ITEM_USE)
      rd_mux = {16'h0, item_use_r};
    else if (araddr_r == ADDR_TRIG_LVL)
      rd_mux = {16'h0, trig_lvl_r};
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ar_got_r <= 1'b0;
      rd_step_r <= 1'b0;
      araddr_r <= 8'h00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= WORD_RST;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= r_fire || (!ar_got_r && !ar_fire);
      rd_step_r <= ar_got_r && !rd_step_r && !s_axi_rvalid;
      if (ar_fire)
      begin
        ar_got_r <= 1'b1;
        araddr_r <= {s_axi_araddr[7:2], 2'h0};
      end
      else if (r_fire)
        ar_got_r <= 1'b0;
      if (rd_step_r)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (r_fire)
        s_axi_rvalid <= 1'b0;
    end
  end

  // continuous run: a new start as soon as ready and idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meas_start <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      meas_start <= ctrl_r.run_continuous && ready_mirror_relay &&
                    !busy_r && !meas_start; // R06
      if (meas_start)
        busy_r <= 1'b1;
      else if (eval_in.done)
        busy_r <= 1'b0;
    end
  end

  // error holds until the next start; a same-cycle error wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      processing_error_flag <= 1'b0;
    else if (eval_in.error)
      processing_error_flag <= 1'b1;
    else if (meas_start)
      processing_error_flag <= 1'b0;
  end

  // unused items are ignored so a partial program can still pass
  assign items_good = &(eval_in.item_ok | ~item_use_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      final_judgement_relay <= 1'b0;
    else if (eval_in.error || (eval_in.done && processing_error_flag))
      final_judgement_relay <= 1'b0; // R04
    else if (eval_in.done)
      final_judgement_relay <= items_good; // R03
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ok_display <= 1'b0;
    else if (ctrl_r.disp_override)
      ok_display <= ctrl_r.disp_value;
    else
      ok_display <= final_judgement_relay; // R05
  end

  always_comb
  begin
    if (ctrl_r.trig_avg_mode)
      trig_nxt = image_stat.avg_level >= trig_lvl_r[7:0] &&
                 image_stat.avg_level <= trig_lvl_r[15:8]; // R09
    else
      trig_nxt = {image_stat.white_area, 1'b0} >=
                 {1'b0, image_stat.image_area}; // R08
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trigger_condition_flag <= 1'b0;
    else if (image_stat.valid)
      trigger_condition_flag <= trig_nxt; // R07
  end

  assign irq_event[IRQ_JUDGE] = eval_in.done;
  assign irq_event[IRQ_ERROR] = eval_in.error;
  assign irq_event[IRQ_TRIG] = image_stat.valid &&
                               trig_nxt != trigger_condition_flag;
  assign irq_clear = (do_write && awaddr_r == ADDR_IRQ_STAT && wstrb_r[0])
                     ? wdata_r[2:0] : 3'h0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_r <= IRQ_RST;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~irq_clear) | irq_event;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_run_idle;
    ctrl_r.run_continuous && ready_mirror_relay && !busy_r && !meas_start;
  endsequence

  a_run_start: assert property (s_run_idle |=> meas_start) // R06
    else $error("continuous run did not start");
  a_judge_good: assert property (eval_in.done && !eval_in.error &&
    !processing_error_flag && items_good |=> final_judgement_relay) // R03
    else $error("good judgement not set");
  a_judge_ng: assert property (eval_in.done && !items_good
    |=> !final_judgement_relay) // R03
    else $error("no-good judgement not cleared");
  a_error_forces: assert property (eval_in.error
    |=> !final_judgement_relay && processing_error_flag) // R04
    else $error("error did not force no-good");
  a_display_follow: assert property (!ctrl_r.disp_override
    |=> ok_display == $past(final_judgement_relay)) // R05
    else $error("display does not follow judgement");
  a_trig_binary: assert property (image_stat.valid && !ctrl_r.trig_avg_mode
    |=> trigger_condition_flag == ($past(image_stat.white_area) * 2 >=
    $past(image_stat.image_area))) // R08
    else $error("binary trigger flag wrong");
  a_trig_average: assert property (image_stat.valid && ctrl_r.trig_avg_mode
    && image_stat.avg_level > trig_lvl_r[15:8]
    |=> !trigger_condition_flag) // R09
    else $error("average trigger flag wrong");
  a_trig_hold: assert property (!image_stat.valid
    |=> $stable(trigger_condition_flag)) // R07
    else $error("trigger flag changed without image");
  a_ready_mirror: assert property (##3 1'b1 |->
    ready_mirror_relay == $past(ready_pin, 2)) // R10
    else $error("ready mirror lags wrong");
  a_const_off: assert property (s_axi_rvalid && araddr_r == ADDR_STAT
    |-> !s_axi_rdata[STAT_CONST_OFF]) // R11
    else $error("constant-off relay read as one");
endmodule
`default_nettype wire

// ---- rtl/arf_pkg.sv ----
// auxiliary relay flags: register map, reset values and carriers
// shared by the relay block top and its calc bank helper
package arf_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_CALC_FIRST = 8'h10;
  localparam logic [7:0] ADDR_CALC_LAST = 8'h1C;
  localparam logic [7:0] ADDR_ITEM_USE = 8'h20;
  localparam logic [7:0] ADDR_TRIG_LVL = 8'h24;

  localparam int CALC_RELAYS = 110;
  localparam int CALC_WORDS = 4;

  localparam int IRQ_JUDGE = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_TRIG = 2;
  localparam int STAT_CONST_OFF = 4;

  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [15:0] ITEM_USE_RST = 16'hFFFF;
  localparam logic [15:0] TRIG_LVL_RST = 16'hC040;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register layout, bit 4 first, down to bit 0 at the bottom
  typedef struct packed {
    logic disp_value;
    logic disp_override;
    logic trig_avg_mode;
    logic run_continuous;
    logic calc_clear;
  } arf_ctrl_t;

  // per-image statistics from the image front end, same clock
  typedef struct packed {
    logic valid;
    logic [17:0] image_area;
    logic [17:0] white_area;
    logic [7:0] avg_level;
  } arf_image_stat_t;

  // measurement outcome from the evaluation engine, same clock
  typedef struct packed {
    logic done;
    logic error;
    logic [15:0] item_ok;
  } arf_eval_t;
endpackage

// ---- rtl/arf_sync2.sv ----
// two-flop synchroniser for one level from a pin
// assumes the level is slow against aclk
`timescale 1ns/1ps
`default_nettype none
module arf_sync2
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic meta_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/arf_calc_bank.sv ----
// general-purpose calculation relays, 32 per word and 14 in the top word, registered read
// assumes one writer; clear has priority over any write
`timescale 1ns/1ps
`default_nettype none
module arf_calc_bank
  import arf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic [1:0] rd_idx,
  output logic [31:0] rdata
);
  logic [31:0] word_r [CALC_WORDS];

  for (genvar i = 0; i < CALC_WORDS; i++)
  begin : g_word
    localparam int BITS = (CALC_RELAYS - i * 32 >= 32) ? 32 :
                          CALC_RELAYS - i * 32;
    localparam logic [31:0] MASK = 32'hFFFF_FFFF >> (32 - BITS);
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        word_r[i] <= WORD_RST;
      else if (clear)
        word_r[i] <= WORD_RST; // R02
      else if (wr_en && wr_idx == 2'(i))
      begin
        for (int b = 0; b < 4; b++)
          if (wstrb[b])
            word_r[i][b*8 +: 8] <= wdata[b*8 +: 8] & MASK[b*8 +: 8]; // R01
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rdata <= WORD_RST;
    else
      rdata <= word_r[rd_idx];
  end

  a_calc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    clear |=> (word_r[0] == 32'h0 && word_r[3] == 32'h0)) // R02
    else $error("calc relays not cleared");
  a_calc_store: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_en && !clear && wr_idx == 2'h1 && wstrb == 4'hF)
    |=> word_r[1] == $past(wdata)) // R01
    else $error("calc relay write lost");
endmodule
`default_nettype wire

// ---- testbench/arf_meas_model.sv ----
// measurement engine stand-in: answers each start with a done pulse
// assumes aclk domain; bench sets item results, error and pace
`timescale 1ns/1ps
`default_nettype none
module arf_meas_model
  import arf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic meas_start,
  input wire logic [15:0] items,
  input wire logic err_req,
  input wire logic slow,
  output arf_pkg::arf_eval_t eval_in
);
  logic [3:0] cnt_r;
  logic busy_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      eval_in <= '0;
    end
    else
    begin
      eval_in.done <= 1'b0;
      eval_in.error <= 1'b0;
      // item bits only mean something with done, so show junk otherwise
      eval_in.item_ok <= ~items;
      if (meas_start && !busy_r)
      begin
        busy_r <= 1'b1;
        cnt_r <= slow ? 4'h9 : 4'h2;
      end
      else if (busy_r)
      begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1)
          eval_in.error <= err_req;
        if (cnt_r == 4'h0)
        begin
          busy_r <= 1'b0;
          eval_in.done <= 1'b1;
          eval_in.item_ok <= items;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/test_arf_relays.sv ----
// self-checking bench for the relay block over axi4-lite
// assumes the measurement stand-in answers every start it sees
`timescale 1ns/1ps
`default_nettype none
module test_arf_relays;
  import arf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic ready_pin = 1'b1;
  arf_image_stat_t image_stat = '0;
  arf_eval_t eval_in;
  logic meas_start, final_judgement_relay, trigger_condition_flag;
  logic processing_error_flag, ok_display, irq;
  logic [15:0] items = 16'hFFFF;
  logic err_req = 1'b0;
  logic slow = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  integer seed = 32'h6954;

  always #12.5 aclk = ~aclk;

  arf_relays i_arf_relays (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ready_pin(ready_pin),
    .image_stat(image_stat), .eval_in(eval_in), .meas_start(meas_start),
    .final_judgement_relay(final_judgement_relay),
    .trigger_condition_flag(trigger_condition_flag),
    .processing_error_flag(processing_error_flag),
    .ok_display(ok_display), .irq(irq));

  arf_meas_model i_arf_meas_model (.aclk(aclk), .aresetn(aresetn),
    .meas_start(meas_start), .items(items), .err_req(err_req),
    .slow(slow), .eval_in(eval_in));

  task automatic give_verdict();
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chkb(input string what, input logic e, input logic g);
    chk(what, {31'h0, e}, {31'h0, g});
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hF, input logic [1:0] er = RESP_OKAY);
    logic [1:0] r;
    axi_write(a, d, s, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic wait_done();
    do
      @(posedge aclk);
    while (eval_in.done !== 1'b1);
    repeat (2) @(posedge aclk);
  endtask

  task automatic count_starts(input int cyc, output int n);
    n = 0;
    repeat (cyc)
    begin
      @(posedge aclk);
      if (meas_start === 1'b1)
        n++;
    end
  endtask

  task automatic send_img(input logic [17:0] w, input logic [17:0] a,
    input logic [7:0] l, input logic e);
    @(posedge aclk);
    image_stat <= '{1'b1, a, w, l};
    @(posedge aclk);
    image_stat.valid <= 1'b0;
    @(posedge aclk);
    #1;
    chkb("trigger_flag", e, trigger_condition_flag);
  endtask

  function automatic logic exp_judge(logic [15:0] it, logic [15:0] u);
    return &(it | ~u);
  endfunction

  function automatic logic exp_bin(logic [17:0] w, logic [17:0] a);
    return {w, 1'b0} >= {1'b0, a};
  endfunction

  initial
  begin : main
    logic [31:0] d;
    logic [31:0] words [4];
    logic [7:0] edges [4];
    logic [15:0] use_m;
    logic [1:0] r;
    logic [7:0] lvl;
    logic [17:0] a;
    logic [17:0] w;
    int n;
    edges = '{8'h1F, 8'h20, 8'hA0, 8'hA1};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_ITEM_USE, 32'h0000FFFF);
    rd_chk(ADDR_TRIG_LVL, 32'h0000C040);
    rd_chk(ADDR_IRQ_MASK, 32'h0);
    rd_chk(ADDR_STAT, 32'h4);
    rd_chk(8'h30, 32'h0, RESP_SLVERR);
    wr(8'h30, 32'h1, 4'hF, RESP_SLVERR);
    wr(ADDR_STAT, 32'hFFFFFFFF);
    rd_chk(ADDR_STAT, 32'h4);
    for (int i = 0; i < CALC_WORDS; i++)
    begin
      words[i] = $random(seed);
      wr(ADDR_CALC_FIRST + 8'(4 * i), words[i]);
    end
    // only 110 relays exist, so the top word keeps 14 bits
    words[3] = words[3] & 32'h3FFF;
    for (int i = 0; i < CALC_WORDS; i++)
      rd_chk(ADDR_CALC_FIRST + 8'(4 * i), words[i]);
    wr(ADDR_CALC_FIRST, 32'h0, 4'h2);
    rd_chk(ADDR_CALC_FIRST, words[0] & 32'hFFFF00FF);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_CALC_FIRST + 8'h4, 32'hFFFFFFFF);
    for (int i = 0; i < CALC_WORDS; i++)
      rd_chk(ADDR_CALC_FIRST + 8'(4 * i), 32'h0);
    wr(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_CALC_FIRST + 8'h4, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    for (int i = 0; i < 6; i++)
    begin
      use_m = 16'($random(seed));
      items <= (i == 0) ? 16'hFFFF : (i == 1) ? ~use_m : 16'($random(seed));
      slow <= i[0];
      wr(ADDR_ITEM_USE, {16'h0, use_m});
      wait_done();
      wait_done();
      chkb("judgement", exp_judge(items, use_m), final_judgement_relay);
      chkb("ok_display", exp_judge(items, use_m), ok_display);
      axi_read(ADDR_STAT, d, r);
      chkb("stat_judge", exp_judge(items, use_m), d[0]);
    end
    err_req <= 1'b1;
    wait_done();
    wait_done();
    chkb("judgement", 1'b0, final_judgement_relay);
    chkb("error_flag", 1'b1, processing_error_flag);
    err_req <= 1'b0;
    items <= 16'hFFFF;
    wait_done();
    wait_done();
    chkb("judgement", 1'b1, final_judgement_relay);
    chkb("error_flag", 1'b0, processing_error_flag);
    wr(ADDR_CTRL, 32'h0A);
    repeat (3) @(posedge aclk);
    chkb("ok_display", 1'b0, ok_display);
    wr(ADDR_CTRL, 32'h2);
    count_starts(80, n);
    chkb("run_starts", 1'b1, n >= 5);
    ready_pin <= 1'b0;
    repeat (12) @(posedge aclk);
    count_starts(40, n);
    chk("starts_not_ready", 32'h0, 32'(n));
    axi_read(ADDR_STAT, d, r);
    chkb("ready_mirror", 1'b0, d[2]);
    ready_pin <= 1'b1;
    wr(ADDR_CTRL, 32'h0);
    repeat (20) @(posedge aclk);
    count_starts(30, n);
    chk("starts_idle", 32'h0, 32'(n));
    rd_chk(ADDR_IRQ_STAT, 32'h3);
    chkb("irq", 1'b0, irq);
    wr(ADDR_IRQ_MASK, 32'h1);
    repeat (3) @(posedge aclk);
    chkb("irq", 1'b1, irq);
    wr(ADDR_IRQ_STAT, 32'h1);
    repeat (3) @(posedge aclk);
    chkb("irq", 1'b0, irq);
    rd_chk(ADDR_IRQ_STAT, 32'h2);
    wr(ADDR_IRQ_MASK, 32'h4);
    send_img(18'd500, 18'd1000, 8'h00, 1'b1);
    send_img(18'd499, 18'd1000, 8'hFF, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      a = 18'($random(seed)) | 18'h1;
      w = 18'({$random(seed)} % (32'(a) + 32'h1));
      send_img(w, a, 8'($random(seed)), exp_bin(w, a));
    end
    chkb("irq", 1'b1, irq);
    wr(ADDR_CTRL, 32'h4);
    wr(ADDR_TRIG_LVL, 32'h0000A020);
    for (int i = 0; i < 12; i++)
    begin
      lvl = (i < 4) ? edges[i] : 8'($random(seed));
      send_img(18'h3FFFF, 18'h0, lvl, lvl >= 8'h20 && lvl <= 8'hA0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
